// ---- mmpt_pkg.sv ----
// Functional notes
// - pulse mode elapsed reads zero when idle
// - time values clear to zero at reset
// - delay mode counts, output on at preset
// - delay mode elapsed holds at preset value
// - delay run inactive: output off, elapsed cleared
// - short delay run pulse never asserts output
// - time values range zero to 99999.000 seconds
// - delay run polarity picks starting transition
// - delay output polarity sets asserted level
// - countdown output on while remaining nonzero
// - countdown decrements while enabled, no reload
// - countdown elapsed counts, clears at zero remaining
// - countdown load while disabled asserts, waits
// - countdown disable freezes both times, output held
// - countdown run polarity picks counting level
// - countdown remaining clears at reset
// - accumulate counts while enabled, holds otherwise
// - accumulate output latches at preset until clear
// - accumulate clear stops, deasserts, zeroes elapsed
// - accumulate keeps counting past preset
// - mode select; off holds output inactive
// - pulse mode asserts output for preset time
// - accumulate clear polarity picks clearing transition

package mmpt_pkg;

    // ************************************************************
    // time representation: whole milliseconds
    // ************************************************************
    localparam int                TIME_W    = 27;
    localparam logic [TIME_W-1:0] TIME_MAX  = 27'h5f5dd18;
    localparam logic [TIME_W-1:0] TIME_ZERO = 27'h0000000;
    localparam logic [TIME_W-1:0] TIME_ONE  = 27'h0000001;

    // ************************************************************
    // prescaler timing
    // ************************************************************
    localparam int CLK_PERIOD_NS  = 20;
    localparam int TICK_PERIOD_NS = 1000000;
    localparam int TICK_CYCLES    = TICK_PERIOD_NS / CLK_PERIOD_NS;

    // ************************************************************
    // modes and states
    // ************************************************************
    typedef enum logic [2:0] {
        MODE_OFF     = 3'h0,
        MODE_PULSE   = 3'h1,
        MODE_DELAY   = 3'h2,
        MODE_ONESHOT = 3'h3,
        MODE_RETAIN  = 3'h4
    } mmpt_mode_e;

    typedef enum logic [1:0] {
        ST_IDLE = 2'h0,
        ST_RUN  = 2'h1,
        ST_DONE = 2'h3
    } mmpt_state_e;

    typedef logic [TIME_W-1:0] mmpt_time_t;

endpackage : mmpt_pkg

// ---- mmpt_tick_gen.sv ----
`timescale 1ns/1ps
`default_nettype none

module mmpt_tick_gen #(
    parameter int CYCLES = 50000
) (
    // clock and reset
    input  wire logic clock,
    input  wire logic rstn,
    // tick out
    output var  logic tick
);

    localparam int CW = (CYCLES > 1) ? $clog2(CYCLES) : 1;
    localparam logic [CW-1:0] CNT_LAST = CW'(CYCLES - 1);
    localparam logic [CW-1:0] CNT_ZERO = '0;
    localparam logic [CW-1:0] CNT_ONE  = CW'(1);

    if (CYCLES < 2) begin : g_bad_cycles
        $error("mmpt_tick_gen: CYCLES must be at least 2");
    end

    logic [CW-1:0] cnt_r;
    logic          tick_r;
    wire           wrap = (cnt_r == CNT_LAST);

    // ************************************************************
    // free-running divider
    // ************************************************************
    always_ff @(posedge clock) begin
        if (!rstn) begin
            cnt_r  <= CNT_ZERO;
            tick_r <= 1'b0;
        end else begin
            cnt_r  <= wrap ? CNT_ZERO : cnt_r + CNT_ONE;
            tick_r <= wrap;
        end
    end

    assign tick = tick_r;

    property p_tick_single;
        @(posedge clock) disable iff (!rstn)
        tick |=> !tick;
    endproperty
    a_tick_single : assert property (p_tick_single) else $error("tick lasted two cycles");

endmodule : mmpt_tick_gen

`default_nettype wire

// ---- mmpt_timer.sv ----
`timescale 1ns/1ps
`default_nettype none

module mmpt_timer
    import mmpt_pkg::*;
#(
    parameter int TICK_CYC = TICK_CYCLES
) (
    // clock and reset
    input  wire logic              clock,
    input  wire logic              rstn,
    // configuration
    input  wire logic [2:0]        modeSel,
    input  wire logic              runActiveHigh,
    input  wire logic              clrActiveHigh,
    input  wire logic              outActiveHigh,
    input  wire logic [TIME_W-1:0] presetTime,
    input  wire logic              loadTime,
    // neighbouring logic inputs
    input  wire logic              runIn,
    input  wire logic              clearIn,
    // outputs
    output var  logic              timerOut,
    output var  logic              timerActive,
    output var  logic [TIME_W-1:0] elapsedTime,
    output var  logic [TIME_W-1:0] remainingTime
);

    if (TICK_CYC < 2) begin : g_bad_tick
        $error("mmpt_timer: TICK_CYC must be at least 2");
    end

    // ************************************************************
    // state
    // ************************************************************
    mmpt_state_e st_r;
    mmpt_state_e st_nxt;
    mmpt_mode_e  modePrev_r;
    mmpt_time_t  elapsed_r;
    mmpt_time_t  elapsed_nxt;
    mmpt_time_t  remaining_r;
    mmpt_time_t  remaining_nxt;
    logic        outAct_r;
    logic        outAct_nxt;
    logic        timerOut_r;
    logic        runPrev_r;
    logic        clrPrev_r;
    logic        tick;

    // ************************************************************
    // millisecond tick
    // ************************************************************
    mmpt_tick_gen #(
        .CYCLES (TICK_CYC)
    ) u_tick (
        .clock  (clock),
        .rstn   (rstn),
        .tick   (tick)
    );

    // ************************************************************
    // input decoding
    // ************************************************************
    wire mmpt_mode_e modeNow    = mmpt_mode_e'(modeSel);
    wire             modeChg    = (modeNow != modePrev_r);
    wire             runLvl     = (runIn == runActiveHigh);
    wire             clrLvl     = (clearIn == clrActiveHigh);
    wire             runStart   = runLvl & ~runPrev_r;
    wire             clrEdge    = clrLvl & ~clrPrev_r;

    // preset clamped to the largest representable time
    wire mmpt_time_t presetEff  = (presetTime > TIME_MAX) ? TIME_MAX : presetTime;
    wire             presetZero = (presetEff == TIME_ZERO);

    // saturating increment keeps every time value in range
    wire mmpt_time_t elapsedInc = (elapsed_r >= TIME_MAX) ? TIME_MAX
                                                          : elapsed_r + TIME_ONE;
    wire mmpt_time_t remainDec  = remaining_r - TIME_ONE;
    wire             remainNz   = (remaining_r != TIME_ZERO);

    // ************************************************************
    // next-state logic
    // ************************************************************
    always_comb begin
        st_nxt        = st_r;
        elapsed_nxt   = elapsed_r;
        remaining_nxt = remaining_r;
        outAct_nxt    = 1'b0;
        if (modeChg) begin
            // restart cleanly in the new mode
            st_nxt      = ST_IDLE;
            elapsed_nxt = TIME_ZERO;
        end else begin
            case (modeNow)
                MODE_PULSE: begin
                    case (st_r)
                        ST_IDLE: begin
                            if (runStart && !presetZero) begin
                                st_nxt      = ST_RUN;
                                elapsed_nxt = TIME_ZERO;
                            end
                        end
                        default: begin
                            if (runStart) begin
                                // retrigger stretches the pulse
                                elapsed_nxt = TIME_ZERO;
                            end else if (tick) begin
                                if (elapsedInc >= presetEff) begin
                                    st_nxt      = ST_IDLE;
                                    elapsed_nxt = TIME_ZERO;
                                end else begin
                                    elapsed_nxt = elapsedInc;
                                end
                            end
                        end
                    endcase
                    outAct_nxt = (st_nxt == ST_RUN);
                end
                MODE_DELAY: begin
                    if (!runLvl) begin
                        st_nxt      = ST_IDLE;
                        elapsed_nxt = TIME_ZERO;
                    end else begin
                        case (st_r)
                            ST_IDLE: begin
                                if (runStart) begin
                                    st_nxt = presetZero ? ST_DONE : ST_RUN;
                                end
                            end
                            ST_RUN: begin
                                if (tick) begin
                                    elapsed_nxt = elapsedInc;
                                    if (elapsedInc >= presetEff) begin
                                        st_nxt = ST_DONE;
                                    end
                                end
                            end
                            default: begin
                                // elapsed holds at the preset
                                elapsed_nxt = elapsed_r;
                            end
                        endcase
                    end
                    outAct_nxt = (st_nxt == ST_DONE);
                end
                MODE_ONESHOT: begin
                    st_nxt = ST_IDLE;
                    if (loadTime) begin
                        remaining_nxt = presetEff;
                        elapsed_nxt   = TIME_ZERO;
                    end else if (runLvl && tick && remainNz) begin
                        remaining_nxt = remainDec;
                        if (remainDec == TIME_ZERO) begin
                            elapsed_nxt = TIME_ZERO;
                        end else begin
                            elapsed_nxt = elapsedInc;
                        end
                    end
                    // no reload: remaining stays at zero once spent
                    outAct_nxt = (remaining_nxt != TIME_ZERO);
                end
                MODE_RETAIN: begin
                    if (clrEdge) begin
                        st_nxt      = ST_IDLE;
                        elapsed_nxt = TIME_ZERO;
                    end else begin
                        if (runLvl && !clrLvl && tick) begin
                            elapsed_nxt = elapsedInc;
                        end
                        if (st_r == ST_DONE) begin
                            st_nxt = ST_DONE;
                        end else if (!clrLvl && elapsed_nxt >= presetEff) begin
                            st_nxt = ST_DONE;
                        end
                    end
                    outAct_nxt = (st_nxt == ST_DONE);
                end
                default: begin
                    st_nxt      = ST_IDLE;
                    elapsed_nxt = TIME_ZERO;
                end
            endcase
        end
    end

    // ************************************************************
    // registers
    // ************************************************************
    always_ff @(posedge clock) begin
        if (!rstn) begin
            st_r        <= ST_IDLE;
            modePrev_r  <= MODE_OFF;
            elapsed_r   <= TIME_ZERO;
            remaining_r <= TIME_ZERO;
            outAct_r    <= 1'b0;
            timerOut_r  <= ~outActiveHigh;
            runPrev_r   <= 1'b0;
            clrPrev_r   <= 1'b0;
        end else begin
            st_r        <= st_nxt;
            modePrev_r  <= modeNow;
            elapsed_r   <= elapsed_nxt;
            remaining_r <= remaining_nxt;
            outAct_r    <= outAct_nxt;
            timerOut_r  <= (outAct_nxt == outActiveHigh);
            runPrev_r   <= runLvl;
            clrPrev_r   <= clrLvl;
        end
    end

    assign timerOut      = timerOut_r;
    assign timerActive   = outAct_r;
    assign elapsedTime   = elapsed_r;
    assign remainingTime = remaining_r;

    // ************************************************************
    // checks
    // ************************************************************
    wire stable1 = !modeChg && (modePrev_r == modeNow);

    property p_pulse_idle_zero;
        @(posedge clock) disable iff (!rstn)
        (modePrev_r == MODE_PULSE && st_r == ST_IDLE) |-> (elapsed_r == TIME_ZERO);
    endproperty
    a_pulse_idle_zero : assert property (p_pulse_idle_zero) else $error("pulse idle elapsed not zero");

    property p_reset_clear;
        @(posedge clock)
        !rstn |=> (elapsed_r == TIME_ZERO && remaining_r == TIME_ZERO && !outAct_r);
    endproperty
    a_reset_clear : assert property (p_reset_clear) else $error("reset left time nonzero");

    property p_range;
        @(posedge clock) disable iff (!rstn)
        (elapsed_r <= TIME_MAX) && (remaining_r <= TIME_MAX);
    endproperty
    a_range : assert property (p_range) else $error("time value over range");

    property p_delay_hold;
        @(posedge clock) disable iff (!rstn)
        (modeNow == MODE_DELAY && stable1 && st_r == ST_DONE && runLvl)
            |=> $stable(elapsed_r) && outAct_r;
    endproperty
    a_delay_hold : assert property (p_delay_hold) else $error("delay elapsed did not hold");

    property p_delay_drop;
        @(posedge clock) disable iff (!rstn)
        (modeNow == MODE_DELAY && !runLvl) |=> (elapsed_r == TIME_ZERO && !outAct_r);
    endproperty
    a_delay_drop : assert property (p_delay_drop) else $error("delay did not drop on run off");

    property p_delay_early;
        @(posedge clock) disable iff (!rstn)
        (modeNow == MODE_DELAY && stable1 && st_r == ST_RUN && !tick)
            |=> (st_r == ST_RUN || !outAct_r);
    endproperty
    a_delay_early : assert property (p_delay_early) else $error("delay output rose early");

    property p_oneshot_out;
        @(posedge clock) disable iff (!rstn)
        (modeNow == MODE_ONESHOT && stable1) |=> (outAct_r == (remaining_r != TIME_ZERO));
    endproperty
    a_oneshot_out : assert property (p_oneshot_out) else $error("countdown output mismatch");

    property p_oneshot_freeze;
        @(posedge clock) disable iff (!rstn)
        (modeNow == MODE_ONESHOT && stable1 && !runLvl && !loadTime)
            |=> $stable(remaining_r) && $stable(elapsed_r);
    endproperty
    a_oneshot_freeze : assert property (p_oneshot_freeze) else $error("countdown moved while held");

    property p_retain_hold;
        @(posedge clock) disable iff (!rstn)
        (modeNow == MODE_RETAIN && stable1 && !runLvl && !clrEdge) |=> $stable(elapsed_r);
    endproperty
    a_retain_hold : assert property (p_retain_hold) else $error("accumulate moved while held");

    property p_retain_latch;
        @(posedge clock) disable iff (!rstn)
        (modeNow == MODE_RETAIN && stable1 && outAct_r && !clrEdge) |=> outAct_r;
    endproperty
    a_retain_latch : assert property (p_retain_latch) else $error("accumulate output fell");

    property p_retain_clear;
        @(posedge clock) disable iff (!rstn)
        (modeNow == MODE_RETAIN && clrEdge) |=> (elapsed_r == TIME_ZERO && !outAct_r);
    endproperty
    a_retain_clear : assert property (p_retain_clear) else $error("clear did not zero timer");

    property p_off_inactive;
        @(posedge clock) disable iff (!rstn)
        (modeNow == MODE_OFF) |=> (!outAct_r && timerOut_r != outActiveHigh);
    endproperty
    a_off_inactive : assert property (p_off_inactive) else $error("off mode output active");

    property p_mode_change;
        @(posedge clock) disable iff (!rstn)
        modeChg |=> (elapsed_r == TIME_ZERO && !outAct_r);
    endproperty
    a_mode_change : assert property (p_mode_change) else $error("mode change did not clear");

endmodule : mmpt_timer

`default_nettype wire

// ---- mmpt_nbr_model.sv ----
`timescale 1ns/1ps
`default_nettype none

// ************************************************************
// neighbouring logic: turns logical requests into raw levels
// ************************************************************
module mmpt_nbr_model (
    // logical requests from the bench
    input  wire logic runReq,
    input  wire logic clrReq,
    // polarity the neighbour must honour
    input  wire logic runActiveHigh,
    input  wire logic clrActiveHigh,
    // raw levels into the timer
    output wire logic runIn,
    output wire logic clearIn
);
    // active request maps to the configured active level
    assign runIn   = runReq ~^ runActiveHigh;
    assign clearIn = clrReq ~^ clrActiveHigh;
endmodule : mmpt_nbr_model

`default_nettype wire

// ---- tb.sv ----
`timescale 1ns/1ps
`default_nettype none

module tb
    import mmpt_pkg::*;
;
    // ************************************************************
    // signals
    // ************************************************************
    localparam int     TC = 4;
    logic              clock, rstn, runActiveHigh, clrActiveHigh, outActiveHigh, loadTime;
    logic              runReq, clrReq;
    logic [2:0]        modeSel;
    logic [TIME_W-1:0] presetTime;
    wire logic         runIn, clearIn, timerOut, timerActive;
    wire logic [TIME_W-1:0] elapsedTime, remainingTime;
    int                failCount = 0;
    int                nTests    = 0;

    mmpt_timer #(.TICK_CYC(TC)) dut_u (
        .clock(clock), .rstn(rstn), .modeSel(modeSel), .runActiveHigh(runActiveHigh),
        .clrActiveHigh(clrActiveHigh), .outActiveHigh(outActiveHigh),
        .presetTime(presetTime), .loadTime(loadTime), .runIn(runIn), .clearIn(clearIn),
        .timerOut(timerOut), .timerActive(timerActive), .elapsedTime(elapsedTime),
        .remainingTime(remainingTime)
    );

    mmpt_nbr_model nbr_u (
        .runReq(runReq), .clrReq(clrReq), .runActiveHigh(runActiveHigh),
        .clrActiveHigh(clrActiveHigh), .runIn(runIn), .clearIn(clearIn)
    );

    initial begin
        clock = 1'b0;
        forever #10 clock = ~clock;
    end

    // ************************************************************
    // helpers
    // ************************************************************
    task wrapUp();
        $display("checks %0d mismatches %0d", nTests, failCount);
        if (failCount == 0 && nTests > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask : wrapUp

    task chk(input string nm, input logic [TIME_W-1:0] exp, input logic [TIME_W-1:0] got);
        nTests++;
        if (got !== exp) begin
            failCount++;
            $display("MISMATCH %s expected %0h seen %0h", nm, exp, got);
        end
    endtask : chk

    task cyc(input int n);
        repeat (n) @(negedge clock);
    endtask : cyc

    // output level must follow the asserted state through the polarity
    task chkOut(input logic act);
        chk("timerActive", {26'h0, act}, {26'h0, timerActive});
        chk("timerOut", {26'h0, act ~^ outActiveHigh}, {26'h0, timerOut});
    endtask : chkOut

    task waitAct(input logic v, input int bound, output int c);
        c = 0;
        while (timerActive !== v) begin
            if (c >= bound) begin
                failCount++;
                $display("MISMATCH wait timerActive expected %0h seen %0h", v, timerActive);
                wrapUp();
            end
            cyc(1);
            c++;
        end
    endtask : waitAct

    task setMode(input logic [2:0] m);
        modeSel = m;
        cyc(2);
        chk("elapsed after mode change", TIME_ZERO, elapsedTime);
        chkOut(1'b0);
    endtask : setMode

    // ************************************************************
    // scenarios
    // ************************************************************
    task scnReset();
        chk("elapsed at reset", TIME_ZERO, elapsedTime);
        chk("remaining at reset", TIME_ZERO, remainingTime);
        chkOut(1'b0);
    endtask : scnReset

    task scnDelay();
        int c;
        presetTime = 27'h0000003;
        for (int p = 1; p >= 0; p--) begin
            runActiveHigh = p[0];
            outActiveHigh = p[0];
            setMode(MODE_DELAY);
            runReq = 1'b1;
            waitAct(1'b1, 20, c);
            chk("delay start to output", 27'h1, {26'h0, (c >= 8 && c <= 14)});
            chkOut(1'b1);
            chk("delay elapsed at preset", presetTime, elapsedTime);
            cyc(3 * TC);
            chk("delay elapsed held", presetTime, elapsedTime);
            runReq = 1'b0;
            cyc(1);
            chk("delay elapsed cleared", TIME_ZERO, elapsedTime);
            chkOut(1'b0);
            runReq = 1'b1;
            for (int i = 0; i < 2 * TC; i++) begin
                cyc(1);
                chk("short pulse output", 27'h0, {26'h0, timerActive});
            end
            runReq = 1'b0;
            cyc(2);
        end
    endtask : scnDelay

    task scnPulse();
        int c;
        outActiveHigh = 1'b1;
        setMode(MODE_PULSE);
        runReq = 1'b1;
        cyc(2);
        chkOut(1'b1);
        runReq = 1'b0;
        waitAct(1'b0, 20, c);
        chk("pulse length", 27'h1, {26'h0, (c >= 6 && c <= 14)});
        cyc(2 * TC);
        chk("pulse elapsed idle", TIME_ZERO, elapsedTime);
    endtask : scnPulse

    task scnCountdown();
        int               c;
        logic [TIME_W-1:0] r;
        logic [TIME_W-1:0] e;
        runActiveHigh = 1'b0;
        setMode(MODE_ONESHOT);
        presetTime = 27'h7ffffff;
        loadTime = 1'b1;
        cyc(1);
        loadTime = 1'b0;
        cyc(1);
        chk("remaining clamped", TIME_MAX, remainingTime);
        presetTime = 27'h0000003;
        loadTime = 1'b1;
        cyc(1);
        loadTime = 1'b0;
        cyc(3 * TC);
        chk("loaded remaining idle", presetTime, remainingTime);
        chkOut(1'b1);
        runReq = 1'b1;
        c = 0;
        while (remainingTime !== 27'h0000002 && c < 20) begin
            cyc(1);
            c++;
        end
        if (remainingTime !== 27'h0000002) begin
            failCount++;
            $display("MISMATCH wait remainingTime expected 2 seen %0h", remainingTime);
            wrapUp();
        end
        runReq = 1'b0;
        cyc(1);
        r = remainingTime;
        e = elapsedTime;
        cyc(3 * TC);
        chk("frozen remaining", r, remainingTime);
        chk("frozen elapsed", e, elapsedTime);
        chk("elapsed plus remaining", presetTime, r + e);
        chkOut(1'b1);
        runReq = 1'b1;
        waitAct(1'b0, 20, c);
        chk("remaining at end", TIME_ZERO, remainingTime);
        chk("elapsed at end", TIME_ZERO, elapsedTime);
        cyc(3 * TC);
        chk("no reload", TIME_ZERO, remainingTime);
        runReq = 1'b0;
    endtask : scnCountdown

    task scnAccum();
        int               c;
        logic [TIME_W-1:0] e;
        runActiveHigh = 1'b1;
        clrActiveHigh = 1'b0;
        outActiveHigh = 1'b0;
        setMode(MODE_RETAIN);
        presetTime = 27'h0000002;
        runReq = 1'b1;
        waitAct(1'b1, 20, c);
        chkOut(1'b1);
        cyc(3 * TC);
        chk("counts past preset", 27'h1, {26'h0, (elapsedTime > presetTime)});
        runReq = 1'b0;
        cyc(1);
        e = elapsedTime;
        cyc(3 * TC);
        chk("accumulate hold", e, elapsedTime);
        chkOut(1'b1);
        runReq = 1'b1;
        clrReq = 1'b1;
        cyc(2);
        chk("cleared elapsed", TIME_ZERO, elapsedTime);
        chkOut(1'b0);
        cyc(3 * TC);
        chk("clear blocks count", TIME_ZERO, elapsedTime);
        clrReq = 1'b0;
        waitAct(1'b1, 20, c);
        setMode(MODE_OFF);
        cyc(3 * TC);
        chkOut(1'b0);
        setMode(3'h7);
        runReq = 1'b0;
    endtask : scnAccum

    // reset in mid-count with low output polarity
    task scnMidReset();
        setMode(MODE_ONESHOT);
        presetTime = 27'h0000005;
        loadTime = 1'b1;
        cyc(1);
        loadTime = 1'b0;
        runReq = 1'b1;
        cyc(2 * TC);
        chk("countdown elapsed before reset", 27'h0000002, elapsedTime);
        chk("countdown remaining before reset", 27'h0000003, remainingTime);
        rstn = 1'b0;
        runReq = 1'b0;
        cyc(2);
        chk("elapsed at mid reset", TIME_ZERO, elapsedTime);
        chk("remaining at mid reset", TIME_ZERO, remainingTime);
        chkOut(1'b0);
        rstn = 1'b1;
        cyc(2);
        chk("remaining after release", TIME_ZERO, remainingTime);
        chk("elapsed after release", TIME_ZERO, elapsedTime);
        chkOut(1'b0);
    endtask : scnMidReset

    // ************************************************************
    // main sequence
    // ************************************************************
    initial begin
        rstn          = 1'b0;
        modeSel       = MODE_OFF;
        runActiveHigh = 1'b1;
        clrActiveHigh = 1'b1;
        outActiveHigh = 1'b1;
        presetTime    = TIME_ZERO;
        loadTime      = 1'b0;
        runReq        = 1'b0;
        clrReq        = 1'b0;
        cyc(8);
        scnReset();
        rstn = 1'b1;
        cyc(2);
        scnDelay();
        scnPulse();
        scnCountdown();
        scnAccum();
        scnMidReset();
        wrapUp();
    end
endmodule : tb

`default_nettype wire
